// *** src/pcs_top.sv ***
// Purpose: Four digital clock synthesis loops with lock and pin control
// Assumes: Config inputs static while locked; ref period below cap
// Notes:   Output clocks are sys_clk based, so they stay at or below 100 MHz
`timescale 1ns/1ps
module pcs_top
  import pcs_pkg::*;
#(
  parameter int LockCycles = pcs_pkg::LOCK_CYCLES
) (
  input  wire logic        sys_clk,               // 200 MHz clock
  input  wire logic        arst_n,                // Async reset, low
  input  wire logic        cfgDone,               // Configuration done
  input  wire logic [3:0]  refPin,                // Reference clocks
  input  wire logic [3:0]  fbPin,                 // External feedback
  input  wire logic [3:0][7:0] mult,              // Multiplier m
  input  wire logic [3:0][4:0] preDiv,            // Pre-divider n
  input  wire logic [3:0][7:0] postDiv,           // Post-divider k
  input  wire logic [3:0][1:0] phaseSel,          // Quarter steps
  input  wire logic [3:0][15:0] delayCyc,         // Signed delay
  input  wire logic [3:0]  fbEn,                  // Use off-chip feedback
  input  wire logic [3:0]  extOutEn,              // Drive clock pin
  input  wire logic [3:0]  lvdsMode,              // Differential mode
  input  wire logic [3:0]  lockEn,                // Lock pin enable
  input  wire logic [3:0]  gpioOut,               // GPIO drive value
  input  wire logic [3:0]  gpioOe,                // GPIO drive enable
  input  wire logic [3:0]  lockPinIn,             // Lock pin level
  output logic      [3:0]  coreClk,               // Internal clocks
  output logic      [3:0]  clkPinOut,             // Clock pin value
  output logic      [3:0]  clkPinOe,              // Clock pin enable
  output logic      [3:0]  lockPinOut,            // Lock pin value
  output logic      [3:0]  lockPinOe,             // Lock pin enable
  output logic      [3:0]  gpioIn                 // Synced pin level
);
  import pcs_pkg::*;

  localparam int MAX_PER_I = LockCycles / (int'(LOCK_EDGES) + 2);
  localparam logic [15:0] MAX_PERIOD = 16'(MAX_PER_I);

  typedef struct packed {
    pcs_loop_t [3:0] lp;
  } pcs_top_t;
  pcs_top_t st;
  pcs_top_t next_st;

  pcs_sync_if #(.W(12)) syncBus ();
  logic [3:0] refS;
  logic [3:0] fbS;

  // All pin inputs cross through one synchroniser
  assign syncBus.raw = {lockPinIn, fbPin, refPin};
  assign refS = syncBus.safe[3:0];
  assign fbS  = syncBus.safe[7:4];

  pcs_sync #(.W(12)) uSync (
    .sys_clk (sys_clk),
    .arst_n  (arst_n),
    .port    (syncBus)
  );

  function automatic logic [31:0] modAdd(input logic [31:0] a,
                                         input logic [31:0] b,
                                         input logic [31:0] w);
    logic [32:0] s;
    s = {1'b0, a} + {1'b0, b};
    if (s >= {1'b0, w}) begin
      s = s - {1'b0, w};
    end
    return s[31:0];
  endfunction

  // A full period folds to zero: same edges, no extra shift
  function automatic logic [31:0] capMul(input logic [15:0] a,
                                         input logic [7:0] m,
                                         input logic [31:0] w);
    logic [31:0] p;
    p = {16'h0000, a} * {24'h00_0000, m};
    return (p >= w) ? 32'h0000_0000 : p;
  endfunction

  logic [31:0] effW   [4];
  logic [31:0] offs   [4];
  logic [11:0] effNk  [4];
  logic [7:0]  effM   [4];
  logic        cfgOk  [4];

  // Per-loop ratio, phase and delay terms
  for (genvar g = 0; g < NUM_LOOPS; g++) begin : gCfg
    logic        lvds;
    logic [4:0]  n;
    logic [7:0]  k;
    logic [31:0] qtr;
    logic [31:0] phOff;
    logic [15:0] dMag;
    logic [31:0] dm;
    logic [31:0] dOff;
    logic [31:0] fm;
    logic [31:0] fOff;
    assign lvds = (g < LVDS_LOOPS) && lvdsMode[g];          // [RULE7]
    // Forwarded clock times bits per clock, no division  [RULE8]
    assign n = lvds ? PRE_MIN : preDiv[g];
    assign k = lvds ? 8'h01 : postDiv[g];
    assign effM[g] = mult[g];
    assign cfgOk[g] = (mult[g] >= MULT_MIN) && (mult[g] <= MULT_MAX)
      && (lvds || ((n >= PRE_MIN) && (n <= PRE_MAX)
      && (k >= POST_MIN) && (k <= POST_MAX)));              // [RULE1]
    // Modulus W: one output cycle per W/m system cycles  [RULE1]
    assign effW[g] = 32'({16'h0000, st.lp[g].period}
                         * {27'h000_0000, n} * {24'h00_0000, k});
    assign effNk[g] = 12'({7'h00, n} * k);
    assign qtr = effW[g] >> 2;
    always_comb begin
      unique case (phaseSel[g])                             // [RULE2]
        2'b00:   phOff = 32'h0000_0000;
        2'b01:   phOff = qtr;
        2'b10:   phOff = effW[g] >> 1;
        2'b11:   phOff = qtr + (effW[g] >> 1);
      endcase
    end
    assign dMag = delayCyc[g][15] ? 16'(-delayCyc[g]) : delayCyc[g];
    assign dm = capMul(dMag, effM[g], effW[g]);             // [RULE3]
    // A larger phase term fires earlier, so positive delay subtracts
    assign dOff = (!delayCyc[g][15] && dm != 0) ? effW[g] - dm : dm;
    // Advance by the measured trip so the pin edge meets ref  [RULE6]
    assign fm = capMul(st.lp[g].fbLag, effM[g], effW[g]);
    assign fOff = st.lp[g].fbDone ? fm : 32'h0;
    assign offs[g] = modAdd(modAdd(phOff, dOff, effW[g]), fOff, effW[g]);
  end

  // Loop engines: measure, lock, synthesise, drive pins
  always_comb begin
    next_st = st;
    for (int i = 0; i < NUM_LOOPS; i++) begin
      logic        refEdge;
      logic        fbEdge;
      logic        match;
      logic [31:0] pos;
      logic [15:0] diff;
      refEdge = refS[i] & ~st.lp[i].refPrev;
      fbEdge  = fbS[i] & ~st.lp[i].fbPrev;
      diff = (st.lp[i].periodCnt > st.lp[i].period)
        ? st.lp[i].periodCnt - st.lp[i].period
        : st.lp[i].period - st.lp[i].periodCnt;
      // Slow references count as absent, bounding lock time  [RULE10]
      match = (diff <= PERIOD_TOL) && (st.lp[i].periodCnt <= MAX_PERIOD);
      pos = modAdd(st.lp[i].acc, offs[i], effW[i]);
      next_st.lp[i].refPrev = refS[i];
      next_st.lp[i].fbPrev  = fbS[i];
      if (st.lp[i].periodCnt != 16'hFFFF) begin
        next_st.lp[i].periodCnt = st.lp[i].periodCnt + 16'h0001;
      end
      if (st.lp[i].fbCnt != 16'hFFFF) begin
        next_st.lp[i].fbCnt = st.lp[i].fbCnt + 16'h0001;
      end
      if (refEdge) begin
        next_st.lp[i].periodCnt = 16'h0001;
        next_st.lp[i].period    = st.lp[i].periodCnt;
        next_st.lp[i].fbCnt     = 16'h0001;  // Same origin as periodCnt
      end
      unique case (st.lp[i].state)
        PCS_HOLD: begin
          if (cfgDone) begin
            next_st.lp[i].state  = PCS_ACQUIRE;            // [RULE9]
            next_st.lp[i].stable = 3'h0;
          end
        end
        PCS_ACQUIRE: begin
          if (refEdge) begin
            next_st.lp[i].stable = match ? st.lp[i].stable + 3'h1 : 3'h0;
            if (match && cfgOk[i]
                && st.lp[i].stable == LOCK_EDGES - 3'h1) begin
              next_st.lp[i].state   = PCS_LOCKED;          // [RULE4]
              next_st.lp[i].acc     = 32'h0000_0000;
              next_st.lp[i].edgeCnt = 12'h000;
              next_st.lp[i].fbDone  = 1'b0;
            end
          end
        end
        PCS_LOCKED: begin
          next_st.lp[i].acc = modAdd(st.lp[i].acc,
                                     {24'h00_0000, effM[i]}, effW[i]);
          if (refEdge && !match) begin
            next_st.lp[i].state  = PCS_ACQUIRE;            // [RULE12]
            next_st.lp[i].stable = 3'h0;
          end else if (st.lp[i].periodCnt
                       > st.lp[i].period + PERIOD_TOL) begin
            next_st.lp[i].state  = PCS_ACQUIRE;            // [RULE12]
            next_st.lp[i].stable = 3'h0;
          end else if (refEdge) begin
            // Realign every n*k reference periods to stop drift
            next_st.lp[i].edgeCnt = st.lp[i].edgeCnt + 12'h001;
            if (st.lp[i].edgeCnt + 12'h001 >= effNk[i]) begin
              next_st.lp[i].edgeCnt = 12'h000;
              next_st.lp[i].acc     = 32'h0000_0000;
            end
          end
          // Trip delay is sampled once per lock, avoiding a hunt
          if (fbEn[i] && fbEdge && !st.lp[i].fbDone) begin
            next_st.lp[i].fbLag  = st.lp[i].fbCnt;         // [RULE6]
            next_st.lp[i].fbDone = 1'b1;
          end
        end
        default: next_st.lp[i].state = PCS_HOLD;
      endcase
      if (!cfgDone) begin
        next_st.lp[i].state = PCS_HOLD;                    // [RULE9]
      end
      next_st.lp[i].coreClk = (next_st.lp[i].state == PCS_LOCKED)
        && (pos < (effW[i] >> 1));
      next_st.lp[i].clkPin = next_st.lp[i].coreClk;
      next_st.lp[i].clkOe  = extOutEn[i];                  // [RULE6]
      // Lock pin or ordinary I/O  [RULE5]
      next_st.lp[i].lockOut = lockEn[i]
        ? (next_st.lp[i].state == PCS_LOCKED) : gpioOut[i];
      next_st.lp[i].lockOe = lockEn[i] | gpioOe[i];
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      st <= '{lp: '{default: LOOP_RST}};
    end else begin
      st <= next_st;
    end
  end

  // Outputs taken straight from state flops
  for (genvar g = 0; g < NUM_LOOPS; g++) begin : gOut
    assign coreClk[g]    = st.lp[g].coreClk;
    assign clkPinOut[g]  = st.lp[g].clkPin;
    assign clkPinOe[g]   = st.lp[g].clkOe;
    assign lockPinOut[g] = st.lp[g].lockOut;
    assign lockPinOe[g]  = st.lp[g].lockOe;
    assign gpioIn[g]     = syncBus.safe[8 + g];

    a_hold_quiet: assert property ( // [RULE9]
      @(posedge sys_clk) disable iff (!arst_n)
      !cfgDone |=> st.lp[g].state == PCS_HOLD && !coreClk[g])
      else $error("loop active before configuration done");
    a_lock_on_edge: assert property ( // [RULE4]
      @(posedge sys_clk) disable iff (!arst_n)
      st.lp[g].state == PCS_ACQUIRE ##1 st.lp[g].state == PCS_LOCKED
      |-> $past(refS[g] & ~st.lp[g].refPrev) && $past(cfgOk[g]))
      else $error("lock taken without a reference edge");
    a_lock_pin: assert property ( // [RULE12]
      @(posedge sys_clk) disable iff (!arst_n)
      lockEn[g] |=> lockPinOe[g]
        && lockPinOut[g] == (st.lp[g].state == PCS_LOCKED))
      else $error("lock pin disagrees with loop state");
    a_gpio_pass: assert property ( // [RULE5]
      @(posedge sys_clk) disable iff (!arst_n)
      !lockEn[g] |=> lockPinOut[g] == $past(gpioOut[g])
        && lockPinOe[g] == $past(gpioOe[g]))
      else $error("unused lock pin not acting as plain I/O");
    a_clk_quiet: assert property ( // [RULE1]
      @(posedge sys_clk) disable iff (!arst_n)
      st.lp[g].state != PCS_LOCKED |-> !coreClk[g])
      else $error("clock running while unlocked");
    a_acc_range: assert property ( // [RULE1]
      @(posedge sys_clk) disable iff (!arst_n)
      st.lp[g].state == PCS_LOCKED |-> st.lp[g].acc < effW[g]
        && offs[g] < effW[g])
      else $error("phase accumulator outside its modulus");
    a_pin_copy: assert property ( // [RULE6]
      @(posedge sys_clk) disable iff (!arst_n)
      clkPinOut[g] == coreClk[g] && clkPinOe[g] == $past(extOutEn[g]))
      else $error("clock pin not following loop clock");
    a_lock_bound: assert property ( // [RULE10]
      @(posedge sys_clk) disable iff (!arst_n)
      st.lp[g].state == PCS_LOCKED |-> st.lp[g].period <= MAX_PERIOD
        + PERIOD_TOL)
      else $error("locked on a reference too slow to bound lock time");
    a_drop_lock: assert property ( // [RULE12]
      @(posedge sys_clk) disable iff (!arst_n)
      st.lp[g].state == PCS_LOCKED && cfgDone
        && st.lp[g].periodCnt > st.lp[g].period + PERIOD_TOL
      |=> st.lp[g].state == PCS_ACQUIRE)
      else $error("lock kept after reference vanished");
  end
endmodule

// *** src/pcs_pkg.sv ***
// Purpose: Shared constants and types of the four-loop clock synthesiser
// Assumes: 200 MHz system clock; configuration inputs are static
// Notes:   Loop output clocks are synthesised digitally on sys_clk
//
// What this block does
// (RULE1) Output frequency is ref times m over n times k; m,k 2..160, n 1..16.
// (RULE2) Output phase steps in quarter periods chosen by configuration.
// (RULE3) Output delay moves earlier or later by up to one output period.
// (RULE4) Lock indicator goes high once the loop locks to its reference.
// (RULE5) Lock indicator optional per loop; unused pin acts as plain I/O.
// (RULE6) Output clock may drive a pin; feedback may come from off-chip.
// (RULE7) Four independent loops; first two also serve differential links.
// (RULE8) Differential mode multiplies forwarded clock up to the bit rate.
// (RULE9) Loop ignores its reference until configuration is done.
// (RULE10) Lock is reached within forty microseconds of a good reference.
// (RULE11) Outside party keeps the oscillator between 200 and 500 MHz.
// (RULE12) Indicator low until first lock and low again on loss of lock.
package pcs_pkg;
  localparam int NUM_LOOPS   = 4;
  localparam int LVDS_LOOPS  = 2;
  localparam int SYS_CLK_MHZ = 200;
  localparam int LOCK_TIME_US = 40;
  // Longest lock time in whole sys_clk cycles
  localparam int LOCK_CYCLES = LOCK_TIME_US * SYS_CLK_MHZ;
  localparam logic [7:0]  MULT_MIN   = 8'h02;
  localparam logic [7:0]  MULT_MAX   = 8'hA0;
  localparam logic [4:0]  PRE_MIN    = 5'h01;
  localparam logic [4:0]  PRE_MAX    = 5'h10;
  localparam logic [7:0]  POST_MIN   = 8'h02;
  localparam logic [7:0]  POST_MAX   = 8'hA0;
  localparam logic [2:0]  LOCK_EDGES = 3'h4;
  localparam logic [15:0] PERIOD_TOL = 16'h0001;

  typedef enum logic [1:0] {
    PCS_HOLD    = 2'b00,
    PCS_ACQUIRE = 2'b01,
    PCS_LOCKED  = 2'b10
  } pcs_state_t;

  typedef struct packed {
    pcs_state_t  state;
    logic [15:0] period;
    logic [15:0] periodCnt;
    logic [2:0]  stable;
    logic [11:0] edgeCnt;
    logic [31:0] acc;
    logic [15:0] fbLag;
    logic [15:0] fbCnt;
    logic        fbDone;
    logic        refPrev;
    logic        fbPrev;
    logic        coreClk;
    logic        clkPin;
    logic        clkOe;
    logic        lockOut;
    logic        lockOe;
  } pcs_loop_t;

  localparam pcs_loop_t LOOP_RST = '{state: PCS_HOLD, default: '0};
endpackage

// *** src/pcs_sync_if.sv ***
// Purpose: Carries raw pin levels to the synchroniser and safe levels back
// Assumes: One sys_clk domain on the safe side
// Notes:   Width set by the instantiating module
`timescale 1ns/1ps
interface pcs_sync_if #(parameter int W = 1) ();
  logic [W-1:0] raw;
  logic [W-1:0] safe;
  modport core (output raw, input safe);
  modport sync (input raw, output safe);
endinterface

// *** src/pcs_sync.sv ***
// Purpose: Two-flop synchroniser for asynchronous pin levels
// Assumes: Inputs are levels, not pulses shorter than a cycle
// Notes:   First stage feeds only the second stage
`timescale 1ns/1ps
module pcs_sync #(parameter int W = 1) (
  input  wire logic sys_clk,   // System clock
  input  wire logic arst_n,    // Async reset, active low
  pcs_sync_if.sync  port       // Raw in, safe out
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } pcs_sync_state_t;
  pcs_sync_state_t st;
  pcs_sync_state_t next_st;

  // Shift chain; metastability settles in s1
  always_comb begin
    next_st.s1 = port.raw;
    next_st.s2 = st.s1;
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign port.safe = st.s2;
endmodule

// *** sim/pcs_board_model.sv ***
// Purpose: Board around the clock block: sources, feedback trace, lock pin
// Assumes: Reference periods are whole sys_clk cycles of 5 ns
// Notes:   Stopped sources rest low; feedback trace has a pull-down,
//          lock pin a pull-up when nobody drives it
`timescale 1ns/1ps
module pcs_board_model (
  input  wire logic [3:0]      run,        // Source enable per loop
  input  wire logic [3:0][7:0] perCyc,     // Period in sys_clk cycles
  input  wire logic [3:0]      clkPinOut,  // Clock pin from device
  input  wire logic [3:0]      clkPinOe,   // Clock pin enable
  input  wire logic [3:0]      lockPinOut, // Lock pin from device
  input  wire logic [3:0]      lockPinOe,  // Lock pin enable
  input  wire logic [3:0]      extVal,     // Level other chips drive
  input  wire logic [3:0]      extOe,      // Other chips drive lock pin
  output logic      [3:0]      refPin,     // Reference clocks
  output logic      [3:0]      fbPin,      // Feedback trace
  output logic      [3:0]      lockPinIn   // Resolved lock pin level
);
  // Sources start 1 ns off the clock grid so sampling never races
  for (genvar i = 0; i < 4; i++) begin : g_src
    initial begin
      refPin[i] = 1'b0;
      #1;
      forever begin
        if (run[i]) begin
          refPin[i] = 1'b1;
          #(perCyc[i] * 2.5);
          refPin[i] = 1'b0;
          #(perCyc[i] * 2.5);
        end else begin
          refPin[i] = 1'b0;
          #5;
        end
      end
    end
  end

  // Trace delay back to the feedback input; pulled low when undriven
  assign #3 fbPin = clkPinOe & clkPinOut;

  // Wire level from both drivers, pull-up when both let go
  assign lockPinIn = (lockPinOe & lockPinOut)
                   | (~lockPinOe & extOe & extVal)
                   | (~lockPinOe & ~extOe);
endmodule

// *** sim/pcs_top_tb.sv ***
// Purpose: Self-checking bench for the four-loop clock synthesiser
// Assumes: Lock limit scaled to 600 cycles; inputs change at falling edge
// Notes:   Frequency is judged by edge counts over whole pattern repeats
`timescale 1ns/1ps
module pcs_top_tb;
  import pcs_pkg::*;
  localparam int LockLimit = 600;
  localparam int RefCyc    = 40;

  typedef struct packed {
    logic [3:0] lockEn, gpioOut, gpioOe, extOutEn, extVal;
    logic [3:0] expOut, expOe, expIn;
  } pcs_row_t;
  pcs_row_t rows [4] = '{
    '{4'h0, 4'hA, 4'hC, 4'h3, 4'h6, 4'hA, 4'hC, 4'hA},
    '{4'h5, 4'hF, 4'h0, 4'hC, 4'hF, 4'hA, 4'h5, 4'hA},
    '{4'hF, 4'h0, 4'h0, 4'hF, 4'h0, 4'h0, 4'hF, 4'h0},
    '{4'h0, 4'h5, 4'hF, 4'h0, 4'hA, 4'h5, 4'hF, 4'h5}};

  logic             sys_clk, arst_n, cfgDone;
  logic [3:0]       refPin, fbPin, fbEn, extOutEn, lvdsMode, lockEn;
  logic [3:0]       gpioOut, gpioOe, lockPinIn, run, extVal, extOe;
  logic [3:0][7:0]  mult, postDiv, perCyc;
  logic [3:0][4:0]  preDiv;
  logic [3:0][1:0]  phaseSel;
  logic [3:0][15:0] delayCyc;
  logic [3:0]       coreClk, clkPinOut, clkPinOe;
  logic [3:0]       lockPinOut, lockPinOe, gpioIn;
  int               n_errors, checks_done, cycles, took, d;
  int               cnt [4];
  int               pinCnt [4];
  realtime          t0;

  pcs_top #(.LockCycles(LockLimit)) dut (
    .sys_clk(sys_clk), .arst_n(arst_n), .cfgDone(cfgDone),
    .refPin(refPin), .fbPin(fbPin), .mult(mult), .preDiv(preDiv),
    .postDiv(postDiv), .phaseSel(phaseSel), .delayCyc(delayCyc),
    .fbEn(fbEn), .extOutEn(extOutEn), .lvdsMode(lvdsMode),
    .lockEn(lockEn), .gpioOut(gpioOut), .gpioOe(gpioOe),
    .lockPinIn(lockPinIn), .coreClk(coreClk), .clkPinOut(clkPinOut),
    .clkPinOe(clkPinOe), .lockPinOut(lockPinOut),
    .lockPinOe(lockPinOe), .gpioIn(gpioIn));

  pcs_board_model board (
    .run(run), .perCyc(perCyc), .clkPinOut(clkPinOut),
    .clkPinOe(clkPinOe), .lockPinOut(lockPinOut), .lockPinOe(lockPinOe),
    .extVal(extVal), .extOe(extOe), .refPin(refPin), .fbPin(fbPin),
    .lockPinIn(lockPinIn));

  task automatic check(input string what, input logic [31:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic final_report();
    $display("Counts: %0d checks, %0d mismatches", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Bounded wait for a lock pattern; took reaches the limit on failure
  task automatic wait_lock(input logic [3:0] want);
    took = 0;
    while (lockPinOut !== want && took < LockLimit) begin
      @(negedge sys_clk);
      took++;
    end
  endtask

  // Rising edges over eight reference periods, a whole pattern repeat
  task automatic count_edges();
    logic [3:0] pc, pp;
    pc = coreClk;
    pp = clkPinOut;
    for (int i = 0; i < 4; i++) begin
      cnt[i] = 0;
      pinCnt[i] = 0;
    end
    repeat (8 * RefCyc) begin
      @(negedge sys_clk);
      for (int i = 0; i < 4; i++) begin
        cnt[i] += int'(coreClk[i] & ~pc[i]);
        pinCnt[i] += int'(clkPinOut[i] & ~pp[i]);
      end
      pc = coreClk;
      pp = clkPinOut;
    end
  endtask

  // Cycles from a rise of loop 1 to the next rise of loop 3
  task automatic phase_gap(output int gap);
    int lim;
    lim = 0;
    gap = 0;
    while (coreClk[1] !== 1'b0 && lim < 100) begin
      @(negedge sys_clk);
      lim++;
    end
    while (coreClk[1] !== 1'b1 && lim < 100) begin
      @(negedge sys_clk);
      lim++;
    end
    while (coreClk[3] !== 1'b0 && gap < 100) begin
      @(negedge sys_clk);
      gap++;
    end
    while (coreClk[3] !== 1'b1 && gap < 100) begin
      @(negedge sys_clk);
      gap++;
    end
  endtask

  // Clock source
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  // Hang guard, well above the roughly 1200 cycles the tests need
  initial begin
    cycles = 0;
    forever begin
      @(posedge sys_clk);
      cycles++;
      if (cycles == 8000) begin
        n_errors++;
        $display("[FAIL] run cut short after %0d cycles", cycles);
        final_report();
      end
    end
  end

  initial begin
    n_errors = 0;
    checks_done = 0;
    arst_n = 1'b0;
    cfgDone = 1'b0;
    run = 4'h0;
    perCyc = {4{8'h28}};
    extOe = 4'hF;
    {lockEn, gpioOut, gpioOe, extOutEn, extVal} = '0;
    {fbEn, lvdsMode} = '0;
    mult = {4{8'h02}};
    preDiv = {4{5'h01}};
    postDiv = {4{8'h02}};
    phaseSel = '0;
    delayCyc = '0;
    repeat (2) @(negedge sys_clk);
    check("coreClk in reset", coreClk, 4'h0);
    check("clkPinOe in reset", clkPinOe, 4'h0);
    arst_n = 1'b1;
    // Pin roles while unlocked: indicator low or plain I/O
    foreach (rows[r]) begin
      {lockEn, gpioOut, gpioOe, extOutEn, extVal} = rows[r][31:12];
      repeat (4) @(negedge sys_clk);
      check("lockPinOut", lockPinOut, rows[r].expOut);
      check("lockPinOe", lockPinOe, rows[r].expOe);
      check("gpioIn", gpioIn, rows[r].expIn);
      check("clkPinOe", clkPinOe, rows[r].extOutEn);
      check("coreClk idle", coreClk, 4'h0);
    end
    $display("Test pin roles done");
    // Ratios kept inside the legal ranges
    mult = {8'h04, 8'h06, 8'h02, 8'h08};
    preDiv = {5'h02, 5'h01, 5'h01, 5'h01};
    postDiv = {8'h02, 8'h03, 8'h02, 8'h02};
    phaseSel = {2'h1, 2'h0, 2'h0, 2'h0};
    {lvdsMode, fbEn, extOutEn, lockEn} = {4'h5, 4'h1, 4'hF, 4'hF};
    run = 4'hF;
    repeat (200) @(negedge sys_clk);
    check("lock before config", lockPinOut, 4'h0);
    cfgDone = 1'b1;
    wait_lock(4'hF);
    check("lock in time", took < LockLimit, 1);
    repeat (100) @(negedge sys_clk);
    count_edges();
    for (int i = 0; i < 4; i++) begin
      d = (lvdsMode[i] && i < LVDS_LOOPS) ? 1 : preDiv[i] * postDiv[i];
      check("core edges", cnt[i], 8 * mult[i] / d);
      check("pin edges", pinCnt[i], 8 * mult[i] / d);
    end
    // Off-chip trace: pin edge lands within a cycle of the reference
    @(posedge refPin[0]);
    t0 = $realtime;
    @(posedge fbPin[0]);
    check("fb align", ($realtime - t0) < 5.0, 1);
    @(negedge sys_clk);
    // Loops 1 and 3 share a frequency; loop 3 sits a quarter away
    phase_gap(d);
    check("quarter step", d == 10 || d == 30, 1);
    // Five cycles of added delay move loop 3 five cycles later
    delayCyc[3] = 16'h0005;
    phase_gap(took);
    check("delay later", took, (d + 5) % RefCyc);
    $display("Test synthesis done");
    run[1] = 1'b0;
    repeat (RefCyc + 20) @(negedge sys_clk);
    check("loss of lock", lockPinOut, 4'hD);
    check("clock stops", coreClk[1], 1'b0);
    run[1] = 1'b1;
    wait_lock(4'hF);
    check("relock in time", took < LockLimit, 1);
    cfgDone = 1'b0;
    repeat (2) @(negedge sys_clk);
    check("config dropped", lockPinOut, 4'h0);
    $display("Test lock loss done");
    final_report();
  end
endmodule
